// ### rtfp_pkg.sv
// rtfp_pkg: constants and carrier types of the tag frame protocol block
// assumes a demodulator below delivering decoded request bytes with frame marks
package rtfp_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int FIELD_ABSENT_TIME_US = 1000;
   localparam int FIELD_ABSENT_CYC =
      (FIELD_ABSENT_TIME_US * (CLK_HZ / 1000000) < 1) ? 1 :
      FIELD_ABSENT_TIME_US * (CLK_HZ / 1000000);
   localparam logic [15:0] CRC_PRESET = 16'hffff;
   localparam logic [15:0] CRC_POLY_REV = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
   localparam int FLG_INVENTORY = 2;
   localparam int FLG_SELECT = 4;
   localparam int FLG_ADDRESS = 5;
   localparam logic [7:0] ERR_OPT_UNSUPPORTED = 8'h03;
   localparam logic [7:0] RSP_FLAGS_OK = 8'h00;
   localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;
   localparam int UID_BYTES = 8;
   localparam int MAX_PARAM = 4;
   localparam logic [63:0] UID_DEFAULT = 64'h0123_4567_89ab_cdef;

   typedef enum {
      TS_POWER_OFF,
      TS_READY,
      TS_QUIET,
      TS_SELECTED
   } rtfp_tag_state_t;

   typedef enum {
      PS_IDLE,
      PS_FLAGS,
      PS_CMD,
      PS_UID,
      PS_BODY,
      PS_DECIDE,
      PS_TX_FLAGS,
      PS_TX_BODY,
      PS_TX_CRC0,
      PS_TX_CRC1,
      PS_TX_EOF
   } rtfp_parse_t;

   typedef struct packed {
      logic sof;
      logic valid;
      logic [7:0] data;
      logic eof;
   } rtfp_rx_t;

   typedef struct packed {
      logic sof;
      logic valid;
      logic [7:0] data;
      logic eof;
   } rtfp_tx_t;

   typedef struct packed {
      logic go;
      logic [7:0] cmd;
      logic [7:0] flags;
   } rtfp_cmd_t;
endpackage

// ### rtfp_core.sv
// rtfp_core: request parser, mode acceptance, tag state machine, response
// assumes bytes arrive on the core clock; field level is an async pin
`timescale 1ns/1ns
module rtfp_core #(
   parameter int FIELD_ABSENT_CYC = rtfp_pkg::FIELD_ABSENT_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_field_ok,
   input wire rtfp_pkg::rtfp_rx_t i_rx,
   input wire logic i_tx_ready,
   input wire logic i_stay_quiet,
   input wire logic i_select_me,
   input wire logic i_reset_ready,
   output rtfp_pkg::rtfp_tx_t o_tx,
   output rtfp_pkg::rtfp_cmd_t o_cmd,
   output logic [1:0] o_tag_state
);
   typedef struct packed {
      logic [2:0] fsync;
      logic [31:0] absent_cnt;
      rtfp_pkg::rtfp_tag_state_t tstate;
      rtfp_pkg::rtfp_parse_t pstate;
      logic [7:0] flags;
      logic [7:0] cmd;
      logic [3:0] cnt;
      logic [63:0] uid_rx;
      logic [15:0] crc;
      logic bad;
      logic err;
      rtfp_pkg::rtfp_tx_t tx;
      rtfp_pkg::rtfp_cmd_t cout;
   } rtfp_state_t;

   rtfp_state_t r;
   rtfp_state_t next_r;
   logic field_now;
   logic answer;
   logic sel;
   logic adr;
   logic inv;

   // uid is a fixed constant, never written
   localparam logic [63:0] UID = rtfp_pkg::UID_DEFAULT;

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ rtfp_pkg::CRC_POLY_REV) : (x >> 1);
      end
      return x;
   endfunction

   assign sel = r.flags[rtfp_pkg::FLG_SELECT];
   assign adr = r.flags[rtfp_pkg::FLG_ADDRESS];
   assign inv = r.flags[rtfp_pkg::FLG_INVENTORY];
   // second and third stage agree: debounced field level
   assign field_now = (r.fsync[1] == r.fsync[2]) ? r.fsync[1] :
                      (r.tstate != rtfp_pkg::TS_POWER_OFF);

   always_comb begin
      answer = 1'b0;
      if (adr && !sel) begin
         // quiet takes addressed non-inventory; any powered state otherwise
         answer = (r.uid_rx == UID) && !(inv && r.tstate ==
                  rtfp_pkg::TS_QUIET);
      end else if (sel && !adr) begin
         answer = (r.tstate == rtfp_pkg::TS_SELECTED);
      end else if (!sel && !adr) begin
         answer = (r.tstate == rtfp_pkg::TS_READY) ||
                  (r.tstate == rtfp_pkg::TS_SELECTED);
      end else begin
         answer = (r.tstate != rtfp_pkg::TS_POWER_OFF);
      end
   end

   always_comb begin
      next_r = r;
      next_r.fsync = {r.fsync[1:0], i_field_ok};
      next_r.tx.sof = 1'b0;
      next_r.tx.eof = 1'b0;
      next_r.cout.go = 1'b0;
      if (!field_now) begin
         if (r.absent_cnt >= 32'(FIELD_ABSENT_CYC - 1)) begin
            next_r.tstate = rtfp_pkg::TS_POWER_OFF;
         end else begin
            next_r.absent_cnt = r.absent_cnt + 32'h1;
         end
      end else begin
         next_r.absent_cnt = 32'h0;
         if (r.tstate == rtfp_pkg::TS_POWER_OFF) begin
            next_r.tstate = rtfp_pkg::TS_READY;
         end
      end
      if (r.tstate != rtfp_pkg::TS_POWER_OFF && field_now) begin
         // command decoder outside steers state; is the reader's duty
         if (i_reset_ready) begin
            next_r.tstate = rtfp_pkg::TS_READY;
         end else if (i_select_me) begin
            next_r.tstate = rtfp_pkg::TS_SELECTED;
         end else if (i_stay_quiet) begin
            next_r.tstate = rtfp_pkg::TS_QUIET;
         end
      end
      case (r.pstate)
         rtfp_pkg::PS_IDLE: begin
            if (i_rx.sof && r.tstate != rtfp_pkg::TS_POWER_OFF) begin
               next_r.crc = rtfp_pkg::CRC_PRESET;
               next_r.cnt = 4'h0;
               next_r.bad = 1'b0;
               next_r.uid_rx = 64'h0;
               next_r.pstate = rtfp_pkg::PS_FLAGS;
            end
         end
         rtfp_pkg::PS_FLAGS, rtfp_pkg::PS_CMD, rtfp_pkg::PS_UID,
         rtfp_pkg::PS_BODY: begin
            if (i_rx.eof) begin
               // eof before a flags byte, a command byte and any uid bytes is short
               next_r.bad = r.bad || (r.pstate == rtfp_pkg::PS_FLAGS) ||
                            (r.pstate == rtfp_pkg::PS_CMD) ||
                            (r.pstate == rtfp_pkg::PS_UID);
               next_r.pstate = rtfp_pkg::PS_DECIDE;
            end else if (i_rx.valid) begin
               next_r.crc = crc_byte(r.crc, i_rx.data);
               if (r.pstate == rtfp_pkg::PS_FLAGS) begin
                  next_r.flags = i_rx.data;
                  next_r.pstate = rtfp_pkg::PS_CMD;
               end else if (r.pstate == rtfp_pkg::PS_CMD) begin
                  next_r.cmd = i_rx.data;
                  // uid field only when the address flag is one
                  next_r.pstate = r.flags[rtfp_pkg::FLG_ADDRESS] ?
                     rtfp_pkg::PS_UID : rtfp_pkg::PS_BODY;
               end else if (r.pstate == rtfp_pkg::PS_UID) begin
                  // lsbyte first: shift in from the top
                  next_r.uid_rx = {i_rx.data, r.uid_rx[63:8]};
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == 4'(rtfp_pkg::UID_BYTES - 1)) begin
                     next_r.pstate = rtfp_pkg::PS_BODY;
                  end
               end
            end
         end
         rtfp_pkg::PS_DECIDE: begin
            next_r.err = adr && sel;
            // residue check covers the crc bytes, so the body may be any
            // length; a frame without the 2-byte crc fails here too
            if (r.bad || r.crc != rtfp_pkg::CRC_RESIDUE || !answer) begin
               next_r.pstate = rtfp_pkg::PS_IDLE;
            end else begin
               next_r.cout.go = !(adr && sel);
               next_r.cout.cmd = r.cmd;
               next_r.cout.flags = r.flags;
               next_r.tx.sof = 1'b1;
               next_r.tx.valid = 1'b0;
               next_r.crc = rtfp_pkg::CRC_PRESET;
               next_r.pstate = rtfp_pkg::PS_TX_FLAGS;
            end
         end
         rtfp_pkg::PS_TX_FLAGS: begin
            if (!r.tx.valid || i_tx_ready) begin
               // response opens with flags, no command code
               next_r.tx.valid = 1'b1;
               next_r.tx.data = r.err ? rtfp_pkg::RSP_FLAGS_ERR :
                                rtfp_pkg::RSP_FLAGS_OK;
               next_r.crc = crc_byte(r.crc, next_r.tx.data);
               next_r.pstate = r.err ? rtfp_pkg::PS_TX_BODY :
                               rtfp_pkg::PS_TX_CRC0;
            end
         end
         rtfp_pkg::PS_TX_BODY: begin
            if (i_tx_ready) begin
               next_r.tx.data = rtfp_pkg::ERR_OPT_UNSUPPORTED;
               next_r.crc = crc_byte(r.crc, rtfp_pkg::ERR_OPT_UNSUPPORTED);
               next_r.pstate = rtfp_pkg::PS_TX_CRC0;
            end
         end
         rtfp_pkg::PS_TX_CRC0: begin
            if (i_tx_ready) begin
               // crc sent inverted, low byte first
               next_r.tx.data = ~r.crc[7:0];
               next_r.pstate = rtfp_pkg::PS_TX_CRC1;
            end
         end
         rtfp_pkg::PS_TX_CRC1: begin
            if (i_tx_ready) begin
               next_r.tx.data = ~r.crc[15:8];
               next_r.pstate = rtfp_pkg::PS_TX_EOF;
            end
         end
         rtfp_pkg::PS_TX_EOF: begin
            if (i_tx_ready) begin
               next_r.tx.valid = 1'b0;
               next_r.tx.eof = 1'b1;
               next_r.pstate = rtfp_pkg::PS_IDLE;
            end
         end
         default: begin
            next_r.pstate = rtfp_pkg::PS_IDLE;
         end
      endcase
      if (!field_now && r.absent_cnt >= 32'(FIELD_ABSENT_CYC - 1)) begin
         // losing power aborts any frame in progress
         next_r.pstate = rtfp_pkg::PS_IDLE;
         next_r.tx = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         r <= '0;
         r.tstate <= rtfp_pkg::TS_POWER_OFF;
         r.pstate <= rtfp_pkg::PS_IDLE;
         r.crc <= rtfp_pkg::CRC_PRESET;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   assign o_tx = r.tx;
   assign o_cmd = r.cout;
   assign o_tag_state = 2'(r.tstate);
endmodule

// ### rtfp_assertions.sv
// checker for rtfp_core: reply causes, reply framing, tag states
// assumes a bind onto rtfp_core; checks pause while the clock enable is low
`timescale 1ns/1ns
module rtfp_assert #(
   parameter int FIELD_ABSENT_CYC = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_field_ok,
   input wire rtfp_pkg::rtfp_rx_t i_rx,
   input wire logic i_tx_ready,
   input wire rtfp_pkg::rtfp_tx_t o_tx,
   input wire rtfp_pkg::rtfp_cmd_t o_cmd,
   input wire logic [1:0] o_tag_state
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b || !i_ce);
   int off_cnt;
   always_ff @(posedge i_core_clk) begin
      off_cnt <= i_field_ok ? 0 : off_cnt + 1;
   end
   sequence s_reply_head;
      o_tx.sof ##1 (o_tx.valid && !o_tx.sof);
   endsequence
   a_reply_cause: assert property (o_tx.sof |-> $past(i_rx.eof, 2))
      else $error("reply without request");
   a_go_reply: assert property (o_cmd.go |-> s_reply_head)
      else $error("accepted request without reply head");
   a_byte_hold: assert property (o_tx.valid && !i_tx_ready |=>
      o_tx.valid && $stable(o_tx.data)) else $error("byte dropped");
   a_eof_whole: assert property (o_tx.eof |->
      !o_tx.valid && $past(o_tx.valid && i_tx_ready))
      else $error("eof mid byte");
   a_wake_field: assert property ((o_tag_state == 2'h0 ##1
      o_tag_state == 2'h1) |-> $past(i_field_ok, 3))
      else $error("woke without field");
   a_field_drop: assert property (off_cnt > FIELD_ABSENT_CYC + 6
      |-> o_tag_state == 2'h0) else $error("still powered");
   a_select_only: assert property (o_cmd.go && o_cmd.flags[4]
      |-> o_tag_state == 2'h3) else $error("select served unselected");
   a_both_flags: assert property (o_cmd.go |->
      !(o_cmd.flags[4] && o_cmd.flags[5])) else $error("bad flags ran");
   a_quiet_general: assert property (o_cmd.go && o_tag_state == 2'h2
      |-> o_cmd.flags[5]) else $error("quiet tag ran general");
endmodule
bind rtfp_core rtfp_assert #(.FIELD_ABSENT_CYC(FIELD_ABSENT_CYC)) u_chk (
   .i_core_clk, .i_rst_b, .i_ce, .i_field_ok, .i_rx, .i_tx_ready,
   .o_tx, .o_cmd, .o_tag_state);

// ### rtfp_reader.sv
// reader model: sends request frames a byte a cycle, paces replies
// assumes the bench calls send and sets i_slow between frames
`timescale 1ns/1ns
module rtfp_reader (
   input wire logic i_core_clk,
   input wire logic i_slow,
   output rtfp_pkg::rtfp_rx_t o_rx,
   output logic o_tx_ready
);
   logic [3:0] pace = 4'h0;
   initial o_rx = '0;
   always @(posedge i_core_clk) begin
      pace <= pace + 4'h1;
   end
   // slow mode stalls every other pair of cycles
   assign o_tx_ready = !i_slow || pace[1];
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
         end
      end
      return ~c;
   endfunction
   task automatic put(input logic s, v, input logic [7:0] d, input logic e);
      @(posedge i_core_clk);
      #1 o_rx = '{s, v, d, e};
   endtask
   // sof and eof data show the inverse so stale bytes never look valid
   task automatic send(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0, bad};
      put(1, 0, ~o_rx.data, 0);
      foreach (q[i]) put(0, 1, q[i], 0);
      put(0, 1, c[7:0], 0);
      put(0, 1, c[15:8], 0);
      put(0, 0, ~c[15:8], 1);
      put(0, 0, c[15:8], 0);
   endtask
endmodule

// ### test_rf_tag_frame_protocol.sv
// bench for rtfp_core: reader model traffic in every tag state
// assumes rtfp_reader and the bound checker are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_rf_tag_frame_protocol;
   localparam int FAC = 8;
   logic i_core_clk = 0, i_rst_b = 0, i_field_ok = 1, slow = 0, rdy;
   logic i_stay_quiet = 0, i_select_me = 0, i_reset_ready = 0, ce = 1;
   rtfp_pkg::rtfp_rx_t rx;
   rtfp_pkg::rtfp_tx_t tx;
   rtfp_pkg::rtfp_cmd_t cmd;
   logic [1:0] st;
   int err_count = 0, total_checks = 0, mst = 0, gos = 0;
   logic [31:0] rnd = 32'hbb187dad;
   logic [7:0] got[$];
   logic [15:0] gcf;
   rtfp_core #(.FIELD_ABSENT_CYC(FAC)) u_dut (.i_core_clk, .i_rst_b,
      .i_ce(ce), .i_field_ok, .i_rx(rx), .i_tx_ready(rdy), .i_stay_quiet,
      .i_select_me, .i_reset_ready, .o_tx(tx), .o_cmd(cmd), .o_tag_state(st));
   rtfp_reader u_rdr (.i_core_clk, .i_slow(slow), .o_rx(rx),
      .o_tx_ready(rdy));
   initial forever #25 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      if (tx.valid && rdy) got.push_back(tx.data);
      if (cmd.go) begin
         gos++;
         gcf = {cmd.cmd, cmd.flags};
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic move(input int k);
      @(posedge i_core_clk);
      #1 {i_reset_ready, i_select_me, i_stay_quiet} = 3'h1 << k;
      @(posedge i_core_clk);
      #1 {i_reset_ready, i_select_me, i_stay_quiet} = 3'h0;
      repeat (2) @(posedge i_core_clk);
      #1;
      mst = k == 0 ? 2 : k == 1 ? 3 : 1;
      `CHK(st, mst[1:0])
   endtask
   task automatic frame(input logic [7:0] fl, input logic bad, miss);
      logic [7:0] q[$];
      logic [7:0] e[$];
      logic [63:0] u;
      logic [15:0] c;
      int g0;
      rnd = lfsr(rnd);
      slow = rnd[3];
      u = rtfp_pkg::UID_DEFAULT ^ {63'h0, miss};
      q = '{fl, rnd[15:8]};
      if (fl[5]) for (int i = 0; i < 8; i++) q.push_back(u[8*i +: 8]);
      for (int i = 0; i < rnd[17:16]; i++) q.push_back(rnd[i*8 +: 8]);
      got = {};
      g0 = gos;
      if (!bad && mst != 0) begin
         if (fl[4] && fl[5]) e = '{8'h01, 8'h03};
         else if (fl[4] ? mst == 3 : fl[5] ? !miss && !(mst == 2 && fl[2])
            : mst != 2) e = '{8'h00};
      end
      c = u_rdr.crc16(e);
      if (e.size() > 0) e = {e, c[7:0], c[15:8]};
      u_rdr.send(q, bad);
      for (int i = 0; i < 100 && !tx.eof; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      @(posedge i_core_clk);
      #1;
      `CHK(got.size(), e.size())
      foreach (e[i]) `CHK(got[i], e[i])
      `CHK(gos - g0, (e.size() > 0 && e[0] == 8'h00) ? 1 : 0)
      if (gos != g0) `CHK(gcf, {q[1], fl})
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #(50 * 30000);
      err_count++;
      finish_test;
   end
   initial begin
      int mv[3];
      mv = '{1, 0, 2};
      repeat (3) @(posedge i_core_clk);
      #1 i_rst_b = 1;
      repeat (6) @(posedge i_core_clk);
      #1;
      mst = 1;
      `CHK(st, 2'h1)
      for (int p = 0; p < 3; p++) begin
         foreach (mv[j]) frame(8'h08 << j, 0, 0);
         frame(8'h24, 0, 0);
         frame(8'h30, 0, 0);
         frame(8'h20, 0, 1);
         frame(8'h00, 1, 0);
         move(mv[p]);
      end
      i_field_ok = 0;
      repeat (FAC + 8) @(posedge i_core_clk);
      #1;
      mst = 0;
      `CHK(st, 2'h0)
      frame(8'h00, 0, 0);
      i_field_ok = 1;
      repeat (6) @(posedge i_core_clk);
      #1;
      mst = 1;
      `CHK(st, 2'h1)
      frame(8'h00, 0, 0);
      // a low enable must hold the state through a select pulse
      ce = 0;
      i_select_me = 1;
      repeat (3) @(posedge i_core_clk);
      #1 i_select_me = 0;
      ce = 1;
      `CHK(st, 2'h1)
      finish_test;
   end
endmodule
